// *** exec_cfg.svh ***
// constants for the instruction execute block: flag positions, update masks, cycle counts
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

`define UPD_NONE 8'h00
`define UPD_ARITH 8'h2F
`define UPD_WORD 8'h1F
`define UPD_LOGIC 8'h0E
`define UPD_SHIFT 8'h0F

`define CYC_ONE 2'h1
`define CYC_WORD 2'h2
`define CYC_IO_BIT 2'h2
`define CYC_SKIP_ONE_WORD 2'h2
`define CYC_SKIP_TWO_WORD 2'h3
`define CYC_BRANCH_TAKEN 2'h2

`define PC_STEP 16'h0001
`define PC_SKIP_ONE_WORD 16'h0002
`define PC_SKIP_TWO_WORD 16'h0003

`define STATUS_RESET 8'h00
`define PC_RESET 16'h0000
`define BYTE_ALL_ONES 8'hFF

`endif

// *** exec_pkg.sv ***
// types shared by the instruction execute block
package exec_pkg;

    typedef enum logic [5:0] {
        op_add, op_add_carry, op_word_immediate_sum,
        op_sub, op_minus_immediate, op_minus_with_borrow, op_minus_immediate_borrow,
        op_word_immediate_minus,
        op_and, op_mask_immediate, op_or, op_merge_immediate, op_xor_registers,
        op_bits_raise, op_bits_lower,
        op_compare_registers, op_compare_with_borrow, op_compare_immediate,
        op_equal_skip, op_reg_bit_clear_skip, op_reg_bit_set_skip,
        op_io_bit_clear_skip, op_io_bit_set_skip,
        op_flag_set_branch, op_flag_clear_branch,
        op_signed_not_less_branch, op_signed_less_branch,
        op_unsigned_higher_branch, op_unsigned_lower_branch,
        op_halfcarry_set_branch, op_halfcarry_clear_branch,
        op_tflag_set_branch, op_tflag_clear_branch,
        op_intr_on_branch, op_intr_off_branch,
        op_io_bit_raise, op_io_bit_drop,
        op_shift_left_zero_fill, op_shift_right_zero_fill,
        op_rotate_left_carry, op_rotate_right_carry
    } exec_op_t;

    typedef enum logic [3:0] {
        alu_add, alu_sub, alu_and, alu_or, alu_xor, alu_clear_bits,
        alu_shl, alu_shr, alu_rol, alu_ror
    } alu_op_t;

    // bit order matches the status register, bit 7 down to bit 0
    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_t;

    typedef struct packed {
        exec_op_t op;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] imm;
        logic [15:0] pair;
        logic [2:0] bit_sel;
        logic [6:0] offset;
        logic [7:0] io_val;
        logic next_two_word;
    } exec_req_t;

    typedef struct packed {
        logic rd_we;
        logic [7:0] rd_data;
        logic pair_we;
        logic [15:0] pair_data;
        logic io_we;
        logic [7:0] io_data;
    } exec_result_t;

endpackage

// *** byte_alu.sv ***
// 8-bit arithmetic, logic and shift unit with its flag outputs
`timescale 1ns/1ps
`include "exec_cfg.svh"
module byte_alu (
    input wire exec_pkg::alu_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic cin_i,
    output logic [7:0] res_o,
    output exec_pkg::flags_t flags_o
);
    import exec_pkg::*;

    logic [8:0] wide;

    always_comb begin
        wide = 9'h000;
        flags_o = '0;
        unique case (op_i)
            alu_add: wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
            alu_sub: wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
            alu_and: wide = {1'b0, a_i & b_i};
            alu_or: wide = {1'b0, a_i | b_i};
            alu_xor: wide = {1'b0, a_i ^ b_i};
            alu_clear_bits: wide = {1'b0, a_i & (`BYTE_ALL_ONES - b_i)};
            alu_shl: wide = {a_i, 1'b0};
            alu_shr: wide = {a_i[0], 1'b0, a_i[7:1]};
            alu_rol: wide = {a_i, cin_i};
            alu_ror: wide = {a_i[0], cin_i, a_i[7:1]};
        endcase
        res_o = wide[7:0];
        flags_o.z = (wide[7:0] == 8'h00);
        flags_o.n = wide[7];
        flags_o.c = wide[8];
        unique case (op_i)
            alu_add: begin
                flags_o.h = (a_i[3] & b_i[3]) | (b_i[3] & ~wide[3]) | (~wide[3] & a_i[3]);
                flags_o.v = (a_i[7] & b_i[7] & ~wide[7]) | (~a_i[7] & ~b_i[7] & wide[7]);
            end
            alu_sub: begin
                flags_o.h = (~a_i[3] & b_i[3]) | (b_i[3] & wide[3]) | (wide[3] & ~a_i[3]);
                flags_o.v = (a_i[7] & ~b_i[7] & ~wide[7]) | (~a_i[7] & b_i[7] & wide[7]);
            end
            // shifts report overflow as sign after the shift against the new carry
            alu_shl, alu_shr, alu_rol, alu_ror: flags_o.v = wide[7] ^ wide[8];
            default: flags_o.v = 1'b0;
        endcase
        flags_o.s = flags_o.n ^ flags_o.v;
    end
endmodule // byte_alu

// *** word_alu.sv ***
// 16-bit add or subtract of a 6-bit immediate on a register pair
`timescale 1ns/1ps
module word_alu (
    input wire logic sub_i,
    input wire logic [15:0] a_i,
    input wire logic [5:0] k_i,
    output logic [15:0] res_o,
    output exec_pkg::flags_t flags_o
);
    import exec_pkg::*;

    always_comb begin
        flags_o = '0;
        res_o = sub_i ? a_i - {10'h000, k_i} : a_i + {10'h000, k_i};
        flags_o.n = res_o[15];
        flags_o.z = (res_o == 16'h0000);
        flags_o.v = sub_i ? (a_i[15] & ~res_o[15]) : (~a_i[15] & res_o[15]);
        flags_o.c = sub_i ? (res_o[15] & ~a_i[15]) : (~res_o[15] & a_i[15]);
        flags_o.s = flags_o.n ^ flags_o.v;
    end
endmodule // word_alu

// *** cpu_instruction_execute.sv ***
// execute stage of an 8-bit core: result, status flags, program counter and cycle timing
// What this block does
// RULE1: register add, with or without carry, writes sum in one cycle; ZCNVH updated.
// RULE2: immediate add to register pair takes two cycles; ZCNVS updated.
// RULE3: subtract register or immediate, optional borrow, one cycle; ZCNVH updated.
// RULE4: immediate subtract from register pair takes two cycles; ZCNVS updated.
// RULE5: and, or, xor one cycle; only Z, N, V change, carry kept.
// RULE6: raise bits ors mask, lower bits ands 0xFF minus mask; ZNV updated.
// RULE7: compares compute difference without storing; ZNVCH updated in one cycle.
// RULE8: equal-skip skips next instruction when registers match; no flags changed.
// RULE9: register-bit skips test a register bit, skip on clear or set.
// RULE10: io-bit skips test an io register bit, skip on clear or set.
// RULE11: generic branches add offset plus one when chosen flag is set/clear.
// RULE12: signed branches taken on N xor V equal zero or one.
// RULE13: unsigned higher taken on carry clear, lower on carry set.
// RULE14: half-carry and T branches follow the tested flag's value.
// RULE15: interrupt branches taken on global interrupt flag one or zero.
// RULE16: io bit raise or drop takes two cycles, flags untouched.
// RULE17: left rotate pulls carry in, left shift fills zero; ZCNV updated.
// RULE18: right rotate pulls carry into bit 7, right shift fills zero.
// RULE19: skip costs 1, 2 or 3 cycles; taken branch one extra.
`timescale 1ns/1ps
`include "exec_cfg.svh"
module cpu_instruction_execute (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire exec_pkg::exec_req_t req_i,
    input wire logic status_load_i,
    input wire exec_pkg::flags_t status_in_i,
    output logic ready_o,
    output logic done_o,
    output exec_pkg::exec_result_t result_o,
    output exec_pkg::flags_t status_flags_reg_o,
    output logic [15:0] pc_o
);
    import exec_pkg::*;

    typedef enum logic {st_idle, st_wait} exec_state_t;

    exec_state_t state;
    logic [1:0] remain;
    exec_result_t pend_result;
    flags_t pend_flags;
    logic [7:0] pend_mask;
    logic [15:0] pend_pc;
    exec_op_t last_op;

    alu_op_t alu_op;
    logic [7:0] alu_b;
    logic alu_cin;
    logic [7:0] alu_res;
    flags_t alu_flags;
    logic [15:0] word_res;
    flags_t word_flags;

    logic accept;
    logic cond;
    logic skip_hit;
    logic [1:0] next_cycles;
    exec_result_t next_result;
    flags_t next_flags;
    logic [7:0] next_mask;
    logic [15:0] next_pc;
    logic [15:0] branch_pc;
    logic [7:0] io_bit;

    assign accept = req_valid_i && ready_o;
    assign io_bit = 8'h01 << req_i.bit_sel;
    assign branch_pc = pc_o + {{9{req_i.offset[6]}}, req_i.offset} + `PC_STEP;

    byte_alu u_byte_alu (
        .op_i(alu_op),
        .a_i(req_i.rd),
        .b_i(alu_b),
        .cin_i(alu_cin),
        .res_o(alu_res),
        .flags_o(alu_flags)
    );

    word_alu u_word_alu (
        .sub_i(req_i.op == op_word_immediate_minus),
        .a_i(req_i.pair),
        .k_i(req_i.imm[5:0]),
        .res_o(word_res),
        .flags_o(word_flags)
    );

    // operand and function selection for the byte unit
    always_comb begin
        alu_op = alu_add;
        alu_b = req_i.rr;
        alu_cin = 1'b0;
        unique case (req_i.op)
            op_add_carry: alu_cin = status_flags_reg_o.c; // [RULE1]
            op_sub, op_compare_registers: alu_op = alu_sub;
            op_minus_immediate, op_compare_immediate: begin
                alu_op = alu_sub;
                alu_b = req_i.imm;
            end
            op_minus_with_borrow, op_compare_with_borrow: begin
                alu_op = alu_sub;
                alu_cin = status_flags_reg_o.c;
            end
            op_minus_immediate_borrow: begin
                alu_op = alu_sub;
                alu_b = req_i.imm;
                alu_cin = status_flags_reg_o.c; // [RULE3]
            end
            op_and: alu_op = alu_and;
            op_mask_immediate: begin
                alu_op = alu_and;
                alu_b = req_i.imm;
            end
            op_or: alu_op = alu_or;
            op_merge_immediate, op_bits_raise: begin
                alu_op = alu_or; // [RULE6]
                alu_b = req_i.imm;
            end
            op_xor_registers: alu_op = alu_xor;
            op_bits_lower: begin
                alu_op = alu_clear_bits; // [RULE6]
                alu_b = req_i.imm;
            end
            op_shift_left_zero_fill: alu_op = alu_shl; // [RULE17]
            op_shift_right_zero_fill: alu_op = alu_shr; // [RULE18]
            op_rotate_left_carry: begin
                alu_op = alu_rol; // [RULE17]
                alu_cin = status_flags_reg_o.c;
            end
            op_rotate_right_carry: begin
                alu_op = alu_ror; // [RULE18]
                alu_cin = status_flags_reg_o.c;
            end
            default: alu_op = alu_add;
        endcase
    end

    // branch and skip conditions
    always_comb begin
        cond = 1'b0;
        unique case (req_i.op)
            op_equal_skip: cond = (req_i.rd == req_i.rr); // [RULE8]
            op_reg_bit_clear_skip: cond = ~req_i.rr[req_i.bit_sel]; // [RULE9]
            op_reg_bit_set_skip: cond = req_i.rr[req_i.bit_sel]; // [RULE9]
            op_io_bit_clear_skip: cond = ~req_i.io_val[req_i.bit_sel]; // [RULE10]
            op_io_bit_set_skip: cond = req_i.io_val[req_i.bit_sel]; // [RULE10]
            op_flag_set_branch: cond = status_flags_reg_o[req_i.bit_sel]; // [RULE11]
            op_flag_clear_branch: cond = ~status_flags_reg_o[req_i.bit_sel]; // [RULE11]
            op_signed_not_less_branch: begin
                cond = ~(status_flags_reg_o.n ^ status_flags_reg_o.v); // [RULE12]
            end
            op_signed_less_branch: begin
                cond = status_flags_reg_o.n ^ status_flags_reg_o.v; // [RULE12]
            end
            op_unsigned_higher_branch: cond = ~status_flags_reg_o.c; // [RULE13]
            op_unsigned_lower_branch: cond = status_flags_reg_o.c; // [RULE13]
            op_halfcarry_set_branch: cond = status_flags_reg_o.h; // [RULE14]
            op_halfcarry_clear_branch: cond = ~status_flags_reg_o.h; // [RULE14]
            op_tflag_set_branch: cond = status_flags_reg_o.t; // [RULE14]
            op_tflag_clear_branch: cond = ~status_flags_reg_o.t; // [RULE14]
            op_intr_on_branch: cond = status_flags_reg_o.i; // [RULE15]
            op_intr_off_branch: cond = ~status_flags_reg_o.i; // [RULE15]
            default: cond = 1'b0;
        endcase
    end

    assign skip_hit = cond && (req_i.op inside {op_equal_skip, op_reg_bit_clear_skip,
        op_reg_bit_set_skip, op_io_bit_clear_skip, op_io_bit_set_skip});

    // result, flag mask, cycle count and next program counter per instruction
    always_comb begin
        next_result = '0;
        next_flags = alu_flags;
        next_mask = `UPD_NONE;
        next_cycles = `CYC_ONE;
        next_pc = pc_o + `PC_STEP;
        next_result.rd_data = alu_res;
        next_result.pair_data = word_res;
        next_result.io_data = req_i.io_val;
        unique case (req_i.op)
            op_add, op_add_carry, op_sub, op_minus_immediate, op_minus_with_borrow,
            op_minus_immediate_borrow: begin
                next_result.rd_we = 1'b1; // [RULE1] [RULE3]
                next_mask = `UPD_ARITH;
            end
            op_word_immediate_sum, op_word_immediate_minus: begin
                next_result.pair_we = 1'b1;
                next_flags = word_flags;
                next_mask = `UPD_WORD;
                next_cycles = `CYC_WORD; // [RULE2] [RULE4]
            end
            op_and, op_mask_immediate, op_or, op_merge_immediate, op_xor_registers,
            op_bits_raise, op_bits_lower: begin
                next_result.rd_we = 1'b1;
                next_mask = `UPD_LOGIC; // [RULE5] [RULE6]
            end
            // compares keep the destination untouched
            op_compare_registers, op_compare_with_borrow, op_compare_immediate: begin
                next_mask = `UPD_ARITH; // [RULE7]
            end
            op_shift_left_zero_fill, op_shift_right_zero_fill, op_rotate_left_carry,
            op_rotate_right_carry: begin
                next_result.rd_we = 1'b1;
                next_mask = `UPD_SHIFT; // [RULE17] [RULE18]
            end
            op_io_bit_raise: begin
                next_result.io_we = 1'b1;
                next_result.io_data = req_i.io_val | io_bit;
                next_cycles = `CYC_IO_BIT; // [RULE16]
            end
            op_io_bit_drop: begin
                next_result.io_we = 1'b1;
                next_result.io_data = req_i.io_val & ~io_bit;
                next_cycles = `CYC_IO_BIT; // [RULE16]
            end
            op_equal_skip, op_reg_bit_clear_skip, op_reg_bit_set_skip,
            op_io_bit_clear_skip, op_io_bit_set_skip: begin
                if (skip_hit && req_i.next_two_word) begin
                    next_cycles = `CYC_SKIP_TWO_WORD; // [RULE19]
                    next_pc = pc_o + `PC_SKIP_TWO_WORD;
                end else if (skip_hit) begin
                    next_cycles = `CYC_SKIP_ONE_WORD; // [RULE19]
                    next_pc = pc_o + `PC_SKIP_ONE_WORD;
                end
            end
            default: begin
                // every remaining code is a conditional branch
                if (cond) begin
                    next_cycles = `CYC_BRANCH_TAKEN; // [RULE19]
                    next_pc = branch_pc; // [RULE11]
                end
            end
        endcase
    end

    // sequencing: one-cycle work completes on the accepting edge
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= st_idle;
            remain <= 2'h0;
            ready_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                st_idle: begin
                    if (accept && next_cycles == `CYC_ONE) begin
                        done_o <= 1'b1;
                    end else if (accept) begin
                        state <= st_wait;
                        remain <= next_cycles - 2'h1;
                        ready_o <= 1'b0;
                    end
                end
                st_wait: begin
                    remain <= remain - 2'h1;
                    if (remain == 2'h1) begin
                        state <= st_idle;
                        ready_o <= 1'b1;
                        done_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // captured work for multi-cycle instructions
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_result <= '0;
            pend_flags <= '0;
            pend_mask <= `UPD_NONE;
            pend_pc <= `PC_RESET;
            last_op <= op_add;
        end else if (accept) begin
            pend_result <= next_result;
            pend_flags <= next_flags;
            pend_mask <= next_mask;
            pend_pc <= next_pc;
            last_op <= req_i.op;
        end
    end

    // write strobes stand only in the completion cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_o <= '0;
        end else if (state == st_idle && accept && next_cycles == `CYC_ONE) begin
            result_o <= next_result;
        end else if (state == st_wait && remain == 2'h1) begin
            result_o <= pend_result;
        end else begin
            result_o.rd_we <= 1'b0;
            result_o.pair_we <= 1'b0;
            result_o.io_we <= 1'b0;
        end
    end

    // an outside load is taken only when the core is idle and not executing
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_flags_reg_o <= `STATUS_RESET;
        end else if (state == st_idle && accept && next_cycles == `CYC_ONE) begin
            status_flags_reg_o <= (status_flags_reg_o & ~next_mask) | (next_flags & next_mask);
        end else if (state == st_wait && remain == 2'h1) begin
            status_flags_reg_o <= (status_flags_reg_o & ~pend_mask) | (pend_flags & pend_mask);
        end else if (status_load_i && state == st_idle && !accept) begin
            status_flags_reg_o <= status_in_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_o <= `PC_RESET;
        end else if (state == st_idle && accept && next_cycles == `CYC_ONE) begin
            pc_o <= next_pc;
        end else if (state == st_wait && remain == 2'h1) begin
            pc_o <= pend_pc;
        end
    end

    property p_word_two;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op inside {op_word_immediate_sum, op_word_immediate_minus}
        |=> !done_o ##1 (done_o && result_o.pair_we);
    endproperty
    a_word_two: assert property (p_word_two) else $error("word op late"); // [RULE2] [RULE4]

    property p_add_one;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op == op_add
        |=> done_o && result_o.rd_we && result_o.rd_data == 8'($past(req_i.rd) + $past(req_i.rr));
    endproperty
    a_add_one: assert property (p_add_one) else $error("add result wrong"); // [RULE1]

    property p_logic_carry;
        @(posedge clk_i) disable iff (!resetn_i)
        done_o && last_op inside {op_and, op_or, op_xor_registers, op_mask_immediate}
        |-> status_flags_reg_o.c == $past(status_flags_reg_o.c) && !status_flags_reg_o.v;
    endproperty
    a_logic_carry: assert property (p_logic_carry) else $error("logic op moved carry"); // [RULE5]

    property p_lower_bits;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op == op_bits_lower
        |=> result_o.rd_data == ($past(req_i.rd) & ~$past(req_i.imm));
    endproperty
    a_lower_bits: assert property (p_lower_bits) else $error("bit lower wrong"); // [RULE6]

    property p_cmp_nowrite;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op inside {op_compare_registers, op_compare_immediate}
        |=> done_o && !result_o.rd_we && status_flags_reg_o.z == ($past(req_i.rd) ==
        ($past(req_i.op) == op_compare_immediate ? $past(req_i.imm) : $past(req_i.rr)));
    endproperty
    a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare misbehaved"); // [RULE7]

    property p_skip_equal;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op == op_equal_skip && req_i.rd == req_i.rr && !req_i.next_two_word
        |=> !done_o ##1 (done_o && pc_o == 16'($past(pc_o, 2) + `PC_SKIP_ONE_WORD));
    endproperty
    a_skip_equal: assert property (p_skip_equal) else $error("equal skip bad"); // [RULE8] [RULE19]

    property p_skip_two_word;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && skip_hit && req_i.next_two_word |=> !done_o [*2] ##1 done_o;
    endproperty
    a_skip_two_word: assert property (p_skip_two_word) else $error("long skip late"); // [RULE19]

    property p_signed_branch;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op == op_signed_not_less_branch
        && (status_flags_reg_o.n ^ status_flags_reg_o.v) |=> done_o && pc_o == $past(pc_o) + 16'h1;
    endproperty
    a_signed_branch: assert property (p_signed_branch) else $error("wrong branch"); // [RULE12]

    property p_io_raise;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op == op_io_bit_raise
        |=> !done_o ##1 (done_o && result_o.io_we
        && status_flags_reg_o == $past(status_flags_reg_o, 2));
    endproperty
    a_io_raise: assert property (p_io_raise) else $error("io raise wrong"); // [RULE16]

    property p_rotate_right;
        @(posedge clk_i) disable iff (!resetn_i)
        accept && req_i.op == op_rotate_right_carry
        |=> result_o.rd_data[7] == $past(status_flags_reg_o.c)
        && status_flags_reg_o.c == $past(req_i.rd[0]);
    endproperty
    a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong"); // [RULE18]

endmodule // cpu_instruction_execute

// *** tb_top.sv ***
// self-checking bench for the instruction execute block
`timescale 1ns/1ps
module tb_top;
    import exec_pkg::*;
    typedef struct {
        exec_op_t op; logic [7:0] a; logic [7:0] b; logic [2:0] sel; flags_t sin;
        logic [15:0] res; flags_t sout; logic [1:0] w; logic [15:0] dpc; int cyc;
    } row_t;
    logic clk_i = 0;
    logic resetn_i = 0;
    logic req_valid_i = 0;
    exec_req_t req_i = '0;
    logic status_load_i = 0;
    flags_t status_in_i = '0;
    logic ready_o;
    logic done_o;
    exec_result_t result_o;
    flags_t status_flags_reg_o;
    logic [15:0] pc_o;
    int failures = 0;
    int total_checks = 0;
    // w: 1 byte result, 2 io result, 3 pair result; b doubles as imm, offset and pair high byte
    row_t rows [39] = '{
        '{op_add,8'h0F,8'h01,3'h0,8'h00,16'h0010,8'h20,2'h1,16'h0001,1},
        '{op_add_carry,8'hFF,8'h00,3'h0,8'h01,16'h0000,8'h23,2'h1,16'h0001,1},
        '{op_sub,8'h80,8'h01,3'h0,8'h00,16'h007F,8'h28,2'h1,16'h0001,1},
        '{op_minus_immediate,8'h00,8'h01,3'h0,8'h00,16'h00FF,8'h25,2'h1,16'h0001,1},
        '{op_minus_with_borrow,8'h05,8'h05,3'h0,8'h01,16'h00FF,8'h25,2'h1,16'h0001,1},
        '{op_minus_immediate_borrow,8'h10,8'h0F,3'h0,8'h03,16'h0,8'h22,2'h1,16'h1,1},
        '{op_and,8'hF0,8'h8F,3'h0,8'h09,16'h0080,8'h05,2'h1,16'h0001,1},
        '{op_xor_registers,8'hAA,8'hAA,3'h0,8'h01,16'h0000,8'h03,2'h1,16'h0001,1},
        '{op_bits_lower,8'hFF,8'h0F,3'h0,8'h00,16'h00F0,8'h04,2'h1,16'h0001,1},
        '{op_bits_raise,8'h01,8'h80,3'h0,8'h00,16'h0081,8'h04,2'h1,16'h0001,1},
        '{op_compare_registers,8'h10,8'h20,3'h0,8'h00,16'h0000,8'h05,2'h0,16'h0001,1},
        '{op_compare_immediate,8'h30,8'h30,3'h0,8'h00,16'h0,8'h02,2'h0,16'h1,1},
        '{op_shift_left_zero_fill,8'h81,8'h00,3'h0,8'h00,16'h0002,8'h09,2'h1,16'h0001,1},
        '{op_rotate_left_carry,8'h80,8'h00,3'h0,8'h00,16'h0000,8'h0B,2'h1,16'h0001,1},
        '{op_rotate_right_carry,8'h01,8'h00,3'h0,8'h01,16'h0080,8'h05,2'h1,16'h0001,1},
        '{op_shift_right_zero_fill,8'h01,8'h00,3'h0,8'h00,16'h0000,8'h0B,2'h1,16'h0001,1},
        '{op_word_immediate_sum,8'hFF,8'hFF,3'h0,8'h00,16'h003E,8'h01,2'h3,16'h0001,2},
        '{op_word_immediate_sum,8'hFF,8'h7F,3'h0,8'h00,16'h803E,8'h0C,2'h3,16'h0001,2},
        '{op_word_immediate_minus,8'h00,8'h81,3'h0,8'h00,16'h80FF,8'h14,2'h3,16'h1,2},
        '{op_flag_set_branch,8'h00,8'h05,3'h1,8'h02,16'h0000,8'h02,2'h0,16'h0006,2},
        '{op_flag_clear_branch,8'h00,8'h05,3'h0,8'h01,16'h0000,8'h01,2'h0,16'h0001,1},
        '{op_signed_not_less_branch,8'h00,8'h7E,3'h0,8'h0C,16'h0,8'h0C,2'h0,16'hFFFF,2},
        '{op_signed_not_less_branch,8'h00,8'h05,3'h0,8'h04,16'h0,8'h04,2'h0,16'h1,1},
        '{op_signed_less_branch,8'h00,8'h05,3'h0,8'h04,16'h0000,8'h04,2'h0,16'h0006,2},
        '{op_unsigned_higher_branch,8'h00,8'h05,3'h0,8'h01,16'h0,8'h01,2'h0,16'h1,1},
        '{op_unsigned_lower_branch,8'h00,8'h05,3'h0,8'h01,16'h0000,8'h01,2'h0,16'h0006,2},
        '{op_halfcarry_clear_branch,8'h00,8'h05,3'h0,8'h20,16'h0,8'h20,2'h0,16'h1,1},
        '{op_halfcarry_set_branch,8'h00,8'h05,3'h0,8'h20,16'h0000,8'h20,2'h0,16'h0006,2},
        '{op_tflag_set_branch,8'h00,8'h05,3'h0,8'h40,16'h0000,8'h40,2'h0,16'h0006,2},
        '{op_intr_off_branch,8'h00,8'h05,3'h0,8'h80,16'h0000,8'h80,2'h0,16'h0001,1},
        '{op_intr_on_branch,8'h00,8'h05,3'h0,8'h80,16'h0000,8'h80,2'h0,16'h0006,2},
        '{op_equal_skip,8'h93,8'h93,3'h0,8'h3F,16'h0000,8'h3F,2'h0,16'h0003,3},
        '{op_equal_skip,8'h10,8'h11,3'h0,8'h3F,16'h0000,8'h3F,2'h0,16'h0001,1},
        '{op_equal_skip,8'h22,8'h22,3'h0,8'h00,16'h0,8'h00,2'h0,16'h2,2},
        '{op_reg_bit_clear_skip,8'h04,8'h04,3'h2,8'h3F,16'h0000,8'h3F,2'h0,16'h0001,1},
        '{op_reg_bit_set_skip,8'h84,8'h84,3'h7,8'h3F,16'h0000,8'h3F,2'h0,16'h0003,3},
        '{op_io_bit_clear_skip,8'h00,8'h00,3'h3,8'h3F,16'h0000,8'h3F,2'h0,16'h0002,2},
        '{op_io_bit_drop,8'hFF,8'h00,3'h0,8'h3F,16'h00FE,8'h3F,2'h2,16'h1,2},
        '{op_io_bit_raise,8'h00,8'h00,3'h4,8'h3F,16'h0010,8'h3F,2'h2,16'h0001,2}
    };

    always #2 clk_i = ~clk_i;

    cpu_instruction_execute dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .status_load_i(status_load_i), .status_in_i(status_in_i),
        .ready_o(ready_o), .done_o(done_o), .result_o(result_o),
        .status_flags_reg_o(status_flags_reg_o), .pc_o(pc_o));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic run(input row_t r);
        logic [15:0] pc0;
        int n;
        @(negedge clk_i);
        status_load_i = 1;
        status_in_i = r.sin;
        @(negedge clk_i);
        status_load_i = 0;
        pc0 = pc_o;
        req_i = '{op: r.op, rd: r.a, rr: r.b, imm: r.b, pair: {r.b, r.a}, bit_sel: r.sel,
            offset: r.b[6:0], io_val: r.a, next_two_word: r.b[7]};
        req_valid_i = 1;
        @(negedge clk_i);
        req_valid_i = 0;
        n = 1;
        while (done_o !== 1'b1 && n < 8) begin
            chk(ready_o, 16'h0000);
            @(negedge clk_i);
            n++;
        end
        chk(n, r.cyc);
        chk(status_flags_reg_o, r.sout);
        chk(pc_o, pc0 + r.dpc);
        chk(result_o.rd_we, r.w == 1);
        chk(result_o.io_we, r.w == 2);
        chk(result_o.pair_we, r.w == 3);
        if (r.w == 1) chk(result_o.rd_data, r.res[7:0]);
        if (r.w == 2) chk(result_o.io_data, r.res[7:0]);
        if (r.w == 3) chk(result_o.pair_data, r.res);
    endtask

    initial begin
        repeat (20) @(negedge clk_i);
        chk(ready_o, 16'h0001);
        chk(done_o, 16'h0000);
        chk(pc_o, 16'h0000);
        resetn_i = 1;
        foreach (rows[i]) run(rows[i]);
        // reset landing mid-way through a two-cycle op must abandon it
        req_valid_i = 1;
        @(negedge clk_i);
        req_valid_i = 0;
        resetn_i = 0;
        @(negedge clk_i);
        chk(ready_o, 16'h0001);
        chk(done_o, 16'h0000);
        chk(pc_o, 16'h0000);
        chk(status_flags_reg_o, 16'h0000);
        chk(result_o.io_we, 16'h0000);
        resetn_i = 1;
        run(rows[0]);
        finish_test();
    end

    initial begin
        #20000;
        failures++;
        finish_test();
    end
endmodule // tb_top
